// *** sim/acc_ctrl_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "acc_map.svh"
module acc_ctrl_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
    logic        comp_above, cpu_wait, cpu_stop, analog_enable, sample_enable;
    logic        conversion_irq, wake_request, main_osc_off, level_above, mid_mode;
    logic [7:0]  trial_code;
    logic [3:0]  pstrb;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          err_count, checks_done, k;
    // short conversion keeps the run brief: two cycles per bit
    acc_ctrl #(.CONV_TIME_US(1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .comp_above(comp_above),
        .cpu_wait(cpu_wait), .cpu_stop(cpu_stop), .analog_enable(analog_enable),
        .sample_enable(sample_enable), .trial_code(trial_code), .conversion_irq(conversion_irq),
        .wake_request(wake_request), .main_osc_off(main_osc_off));
    // single analog input held at A5h in mid mode, else at a rail
    assign comp_above = mid_mode ? (trial_code <= 8'hA5) : level_above;
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task finish_test;
        if (err_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_count++;
            finish_test();
        end
    endtask : xfer
    task automatic wait_done;
        int i;
        i = 0;
        do begin
            xfer(1'b0, `ACC_ADDR_CONTROL, 32'h0);
            i++;
        end while (rd[6] !== 1'b1 && i < 40);
        if (i >= 40) begin
            err_count++;
            finish_test();
        end
    endtask : wait_done
    initial begin
        {presetn, psel, penable, pwrite, level_above, mid_mode, cpu_wait, cpu_stop} = 8'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        err_count = 0;
        checks_done = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, `ACC_ADDR_CONTROL, 32'h0);
        chk("ctrl reset", rd, 32'h40);
        xfer(1'b0, 12'h34C, 32'h0);
        chk("unmapped err", {31'h0, se}, 32'h1);
        for (k = 0; k < 2; k++) begin
            level_above <= k[0];
            xfer(1'b1, `ACC_ADDR_CONTROL, 32'h10);
            xfer(1'b0, `ACC_ADDR_CONTROL, 32'h0);
            chk("zero write keeps done", rd, 32'h50);
            xfer(1'b1, `ACC_ADDR_CONTROL, 32'h30);
            xfer(1'b0, `ACC_ADDR_CONTROL, 32'h0);
            chk("start clears done", rd, 32'h10);
            wait_done();
            xfer(1'b0, `ACC_ADDR_RESULT, 32'h0);
            chk("result code", rd, k ? 32'hFF : 32'h00);
        end
        mid_mode <= 1'b1;
        xfer(1'b1, `ACC_ADDR_CONTROL, 32'h30);
        wait_done();
        xfer(1'b0, `ACC_ADDR_RESULT, 32'h0);
        chk("mid scale code", rd, 32'hA5);
        mid_mode <= 1'b0;
        // restart well past the minimum run, before the first would finish
        xfer(1'b1, `ACC_ADDR_CONTROL, 32'h30);
        repeat (10) @(posedge pclk);
        xfer(1'b1, `ACC_ADDR_CONTROL, 32'h30);
        repeat (10) @(posedge pclk);
        xfer(1'b0, `ACC_ADDR_CONTROL, 32'h0);
        chk("restart abandons", rd, 32'h10);
        wait_done();
        repeat (40) @(posedge pclk);
        chk("single shot", {31'h0, sample_enable}, 32'h0);
        xfer(1'b1, `ACC_ADDR_CONTROL, 32'h90);
        repeat (2) @(posedge pclk);
        chk("irq", {31'h0, conversion_irq}, 32'h1);
        cpu_wait <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("wake", {31'h0, wake_request}, 32'h1);
        cpu_wait <= 1'b0;
        xfer(1'b1, `ACC_ADDR_MODE, 32'h0);
        xfer(1'b1, `ACC_ADDR_CONTROL, 32'h10);
        cpu_stop <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("stop off", {31'h0, analog_enable}, 32'h0);
        xfer(1'b1, `ACC_ADDR_CONTROL, 32'h30);
        xfer(1'b0, `ACC_ADDR_CONTROL, 32'h0);
        chk("stop ignores start", rd, 32'h50);
        cpu_stop <= 1'b0;
        xfer(1'b1, `ACC_ADDR_MODE, 32'h0);
        xfer(1'b1, `ACC_ADDR_CONTROL, 32'h00);
        xfer(1'b1, `ACC_ADDR_CONTROL, 32'h20);
        xfer(1'b0, `ACC_ADDR_CONTROL, 32'h0);
        chk("off ignores start", rd, 32'h40);
        xfer(1'b1, `ACC_ADDR_CONTROL, 32'h04);
        repeat (2) @(posedge pclk);
        chk("osc off pin", {31'h0, main_osc_off}, 32'h1);
        xfer(1'b0, `ACC_ADDR_CONTROL, 32'h0);
        chk("osc off readback", rd, 32'h44);
        finish_test();
    end
endmodule : acc_ctrl_tb_top
`default_nettype wire

// *** sim/acc_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "acc_map.svh"
module acc_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cpu_stop,
    input wire logic        analog_enable,
    input wire logic        sample_enable,
    input wire logic        conversion_irq,
    input wire logic        wake_request,
    input wire logic        main_osc_off
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_ctl;
    logic mapped;
    assign wr_ctl = psel && !penable && pwrite && paddr == `ACC_ADDR_CONTROL && pstrb[0];
    assign mapped = paddr inside {`ACC_ADDR_RESULT, `ACC_ADDR_CONTROL, `ACC_ADDR_MODE};
    bus_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    map_error_a: assert property (pready |-> pslverr == !mapped)
        else $error("error response wrong for address");
    start_reads_a: assert property (pready && paddr == `ACC_ADDR_CONTROL |-> prdata[5] == 1'b0)
        else $error("start bit read back");
    osc_bit_a: assert property (wr_ctl |-> ##2 main_osc_off == $past(pwdata[2], 2))
        else $error("oscillator bit not written");
    // irq drops two cycles after a start since done clears at once
    done_clear_a: assert property (wr_ctl && pwdata[5] && pwdata[4]
        && analog_enable && !cpu_stop |-> ##2 !conversion_irq)
        else $error("start did not clear done");
    wake_irq_a: assert property (wake_request |-> conversion_irq)
        else $error("wake without interrupt");
    stop_off_a: assert property (cpu_stop [*3] |-> !analog_enable)
        else $error("converter on in stop");
    off_idle_a: assert property (!analog_enable [*2] |-> !sample_enable)
        else $error("converting while off");
    conv_len_a: assert property ($rose(sample_enable) |-> sample_enable [*8])
        else $error("conversion too short");
    cover property ($rose(conversion_irq));
    cover property (wake_request);
    cover property (pready && pslverr);
endmodule : acc_monitor
bind acc_ctrl acc_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_stop(cpu_stop), .analog_enable(analog_enable),
    .sample_enable(sample_enable), .conversion_irq(conversion_irq),
    .wake_request(wake_request), .main_osc_off(main_osc_off));
`default_nettype wire

// *** src/acc_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "acc_map.svh"

// How it works
// - input at or above top reference yields FFh, no overflow flag
// - input at or below bottom reference yields 00h
// - eight-bit result, 256 equal steps between references
// - each finished conversion lands in read-only result register
// - writing start begins a conversion and clears done at once; a finish in the same cycle keeps it set
// - hardware sets done on completion; result valid only while set
// - interrupt request while irq enable and done are both set
// - one conversion per start write, no continuous mode
// - start during a conversion abandons it and begins afresh
// - start bit is write-only and reads as zero
// - done clears only by starting; writing zero leaves it
// - wait mode keeps converting and wakes core; stop disables it
// - power off switches converter off; no conversion while off
// - control register: irq enable b7, done b6, start b5, power b4
// - control register resets to 40h
// - result register sits just below the control register
// - power bit one switches converter on, zero off
module acc_ctrl #(
    parameter int CONV_TIME_US = `ACC_CONV_TIME_US,
    parameter int CLK_MHZ      = `ACC_CLK_MHZ
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        comp_above,
    input  wire logic        cpu_wait,
    input  wire logic        cpu_stop,
    output logic             analog_enable,
    output logic             sample_enable,
    output logic [7:0]       trial_code,
    output logic             conversion_irq,
    output logic             wake_request,
    output logic             main_osc_off
);
    // 1400 cycles by default, split evenly over eight bit decisions
    localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
    localparam int BIT_CYCLES  = (CONV_CYCLES / 8 < 1) ? 1 : CONV_CYCLES / 8;

    logic                     conversion_irq_enable_reg;
    logic                     conversion_done_reg;
    logic                     converter_power_on_reg;
    logic                     osc_off_reg;
    acc_pkg::acc_code_t       result_data_reg;
    acc_pkg::acc_power_mode_e mode_reg;

    logic                     setup;
    logic                     wr_ctrl;
    logic                     wr_mode;
    logic                     start_req;
    logic                     conv_allowed;
    logic                     sar_busy;
    logic                     sar_valid;
    logic                     sar_finish;
    acc_pkg::acc_code_t       sar_trial;
    acc_pkg::acc_code_t       sar_code;
    logic [31:0]              rdata_next;
    logic                     err_next;

    // answer in the access phase with zero wait states
    assign setup     = psel && !penable;
    assign wr_ctrl   = setup && pwrite && pstrb[0] && (paddr == `ACC_ADDR_CONTROL);
    assign wr_mode   = setup && pwrite && pstrb[0] && (paddr == `ACC_ADDR_MODE);

    assign conv_allowed = converter_power_on_reg &&
                          (mode_reg != acc_pkg::ACC_STOP);
    // only a one starts; a written zero has no effect
    assign start_req = wr_ctrl && pwdata[`ACC_BIT_START] && conv_allowed;

    acc_sar #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_sar (
        .pclk        (pclk),
        .presetn     (presetn),
        .go          (start_req),
        .abort       (!conv_allowed),
        .comp_above  (comp_above),
        .busy        (sar_busy),
        .trial_valid (sar_valid),
        .trial_code  (sar_trial),
        .finish      (sar_finish),
        .code        (sar_code)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_irq_enable_reg <= 1'b0;
            converter_power_on_reg    <= 1'b0;
            osc_off_reg               <= 1'b0;
        end else if (wr_ctrl) begin
            conversion_irq_enable_reg <= pwdata[`ACC_BIT_IRQ_EN];
            converter_power_on_reg    <= pwdata[`ACC_BIT_POWER];
            osc_off_reg               <= pwdata[`ACC_BIT_OSC_OFF];
        end
    end

    // done: start clears, finish sets; set wins when both share a cycle,
    // the restarted run then sets it again on its own finish
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_done_reg <= 1'b1;
        end else if (sar_finish) begin
            conversion_done_reg <= 1'b1;
        end else if (start_req) begin
            conversion_done_reg <= 1'b0;
        end
    end

    // code is the raw successive approximation: full and zero scale saturate
    // naturally to FFh / 00h with no overflow flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_data_reg <= `ACC_CODE_ZERO;
        end else if (sar_finish) begin
            result_data_reg <= sar_code;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= acc_pkg::ACC_RUN;
        end else if (wr_mode) begin
            case (pwdata[1:0])
                2'h1:    mode_reg <= acc_pkg::ACC_WAIT;
                2'h2:    mode_reg <= acc_pkg::ACC_STOP;
                default: mode_reg <= acc_pkg::ACC_RUN;
            endcase
        end else if (cpu_stop) begin
            mode_reg <= acc_pkg::ACC_STOP;
        end else if (cpu_wait) begin
            mode_reg <= acc_pkg::ACC_WAIT;
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        err_next   = 1'b0;
        case (paddr)
            `ACC_ADDR_RESULT:  rdata_next[7:0] = result_data_reg;
            `ACC_ADDR_CONTROL: begin
                rdata_next[`ACC_BIT_IRQ_EN]  = conversion_irq_enable_reg;
                rdata_next[`ACC_BIT_DONE]    = conversion_done_reg;
                rdata_next[`ACC_BIT_START]   = 1'b0;
                rdata_next[`ACC_BIT_POWER]   = converter_power_on_reg;
                rdata_next[`ACC_BIT_OSC_OFF] = osc_off_reg;
            end
            `ACC_ADDR_MODE:    rdata_next[1:0] = mode_reg;
            default:           err_next = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && err_next;
            prdata  <= (setup && !pwrite) ? rdata_next : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_irq <= 1'b0;
            wake_request   <= 1'b0;
            analog_enable  <= 1'b0;
            sample_enable  <= 1'b0;
            trial_code     <= 8'h00;
            main_osc_off   <= 1'b0;
        end else begin
            conversion_irq <= conversion_irq_enable_reg && conversion_done_reg;
            // stop mode never wakes the core
            wake_request   <= conversion_irq_enable_reg && conversion_done_reg &&
                              (mode_reg == acc_pkg::ACC_WAIT);
            analog_enable  <= conv_allowed;
            sample_enable  <= sar_busy && sar_valid;
            trial_code     <= sar_trial;
            main_osc_off   <= osc_off_reg;
        end
    end
endmodule : acc_ctrl

`default_nettype wire

// *** src/acc_map.svh ***
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// register index times four gives the byte address on the word-wide bus
`define ACC_IDX_RESULT      8'hD0
`define ACC_IDX_CONTROL     8'hD1
`define ACC_IDX_MODE        8'hD2
`define ACC_ADDR_RESULT     12'h340
`define ACC_ADDR_CONTROL    12'h344
`define ACC_ADDR_MODE       12'h348

`define ACC_BIT_IRQ_EN      7
`define ACC_BIT_DONE        6
`define ACC_BIT_START       5
`define ACC_BIT_POWER       4
`define ACC_BIT_OSC_OFF     2

`define ACC_CTRL_RESET      8'h40
`define ACC_CTRL_WMASK      8'h94
`define ACC_MODE_RESET      2'h0

`define ACC_CODE_FULL       8'hFF
`define ACC_CODE_ZERO       8'h00
`define ACC_CODE_STEPS      256

`define ACC_CLK_MHZ         20
`define ACC_CONV_TIME_US    70

`endif

// *** src/acc_pkg.sv ***
package acc_pkg;

    typedef enum logic [1:0] {
        ACC_RUN,
        ACC_WAIT,
        ACC_STOP
    } acc_power_mode_e;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_SAMPLE,
        ACC_CONVERT,
        ACC_FINISH
    } acc_conv_state_e;

    typedef logic [7:0] acc_code_t;

endpackage : acc_pkg

// *** src/acc_sar.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "acc_map.svh"

// one successive approximation step per BIT_CYCLES cycles, msb first
module acc_sar #(
    parameter int BIT_CYCLES = 175
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          go,
    input  wire logic          abort,
    input  wire logic          comp_above,
    output logic               busy,
    output logic               trial_valid,
    output acc_pkg::acc_code_t trial_code,
    output logic               finish,
    output acc_pkg::acc_code_t code
);
    localparam int CW = $clog2(BIT_CYCLES + 1);

    logic [CW-1:0]      tick_reg;
    logic [2:0]         bit_reg;
    acc_pkg::acc_code_t sar_reg;
    logic               step;
    logic [7:0]         kept;

    // comparator clear means trial too high: drop the bit
    assign kept        = comp_above ? sar_reg : (sar_reg & ~(8'h01 << bit_reg));
    assign step        = busy && (tick_reg == CW'(BIT_CYCLES - 1));
    assign trial_valid = busy;
    assign trial_code  = sar_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy     <= 1'b0;
            tick_reg <= '0;
            bit_reg  <= 3'h7;
            sar_reg  <= 8'h00;
            finish   <= 1'b0;
            code     <= 8'h00;
        end else begin
            finish <= 1'b0;
            if (go) begin
                // restart drops any half-done approximation
                busy     <= 1'b1;
                tick_reg <= '0;
                bit_reg  <= 3'h7;
                sar_reg  <= 8'h80;
            end else if (abort) begin
                busy <= 1'b0;
            end else if (busy) begin
                tick_reg <= step ? '0 : tick_reg + CW'(1);
                if (step) begin
                    if (bit_reg == 3'h0) begin
                        busy   <= 1'b0;
                        finish <= 1'b1;
                        code   <= kept;
                    end else begin
                        bit_reg <= bit_reg - 3'h1;
                        sar_reg <= kept | (8'h01 << (bit_reg - 3'h1));
                    end
                end
            end
        end
    end
endmodule : acc_sar

`default_nettype wire
